// File: stop_seq_pkg.sv
package stop_seq_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned TIME_TICK_US  = 10_000;
    localparam int unsigned TICK_CYCLES   =
        (CLK_HZ / 1_000_000) * TIME_TICK_US;

    // ------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STOP_STYLE   = 8'h00;
    localparam logic [7:0] ADDR_BRAKE_FREQ   = 8'h04;
    localparam logic [7:0] ADDR_DEMAG_WAIT   = 8'h08;
    localparam logic [7:0] ADDR_BRAKE_CUR    = 8'h0c;
    localparam logic [7:0] ADDR_BRAKE_DUR    = 8'h10;
    localparam logic [7:0] ADDR_DEADTIME     = 8'h14;
    localparam logic [7:0] ADDR_SWITCH_POINT = 8'h18;
    localparam logic [7:0] ADDR_HALT_THRESH  = 8'h1c;
    localparam logic [7:0] ADDR_HALT_SOURCE  = 8'h20;
    localparam logic [7:0] ADDR_HALT_QUAL    = 8'h24;
    localparam logic [7:0] ADDR_RUN_GUARD    = 8'h28;
    localparam logic [7:0] ADDR_MAX_FREQ     = 8'h2c;
    localparam logic [7:0] ADDR_STATUS       = 8'h30;

    // ------------------------------------------------------------
    // Limits (frequency 0.01 Hz, time 0.01 s, current 0.1 %)
    // ------------------------------------------------------------
    localparam logic [15:0] LIM_HALT_THRESH = 16'h2710;
    localparam logic [15:0] LIM_DEMAG_WAIT  = 16'h0bb8;
    localparam logic [15:0] LIM_BRAKE_CUR   = 16'h03e8;
    localparam logic [15:0] LIM_BRAKE_DUR   = 16'h1388;
    localparam logic [23:0] LIM_DEADTIME    = 24'h057e40;
    localparam logic [15:0] LIM_HALT_QUAL   = 16'h2710;
    localparam logic [1:0]  LIM_SWITCH      = 2'h2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_HALT_THRESH = 16'h0032;
    localparam logic [15:0] RST_HALT_QUAL   = 16'h0032;
    localparam logic [1:0]  RST_SWITCH      = 2'h1;
    localparam logic [15:0] RST_MAX_FREQ    = 16'h1388;
    localparam logic [15:0] RST_START_FREQ  = 16'h0032;

    // ------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_GUARD_BIT = 4;
    localparam int unsigned ST_HALT_BIT  = 5;
    localparam int unsigned ST_REV_BIT   = 6;

    typedef enum logic [1:0] {
        SW_ZERO,
        SW_START,
        SW_HALT
    } switch_point_t;

    typedef struct packed {
        logic        stopStyle;
        logic [15:0] brakeStartFreq;
        logic [15:0] demagWait;
        logic [15:0] brakeCurrent;
        logic [15:0] brakeDuration;
        logic [23:0] deadtime;
        logic [1:0]  switchPoint;
        logic [15:0] haltThreshold;
        logic        haltSource;
        logic [15:0] haltQualify;
        logic        runGuard;
        logic [15:0] maxFreq;
    } stop_cfg_t;

    typedef struct packed {
        logic        outputEnable;
        logic        brakeActive;
        logic [15:0] brakeLevel;
        logic        rampDown;
        logic        reverseOut;
    } drive_cmd_t;

    function automatic logic [15:0] clamp16(input logic [15:0] v,
                                            input logic [15:0] lim);
        clamp16 = (v > lim) ? lim : v;
    endfunction

endpackage

// File: tick_timer.sv
`timescale 1ns/10ps
module tick_timer
    import stop_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        tick,
    input  wire logic        start,
    input  wire logic [23:0] duration,
    // Status
    output logic             done
);

    logic [23:0] count;
    logic        running;

    assign done = running && (count >= duration);

    always_ff @(posedge clk) begin
        if (!rst_n || start) begin
            count   <= 24'h000000;
            running <= start;
        end else if (done) begin
            running <= 1'b0;
        end else if (running && tick) begin
            count <= count + 24'h000001;
        end
    end

endmodule

// File: stop_brake_seq.sv
// Overview of operation
// - Ramped stop lowers frequency, stops at halt speed threshold.
// - Coasting stop from run cuts output at once; a stop during a reversal ramp still ramps down.
// - Output blocked for demag wait before DC braking begins.
// - Brake current is percent of rated output, 0-100.0, default 0.
// - DC braking lasts the set duration, 0-50.0 s, default 0.
// - Brake start frequency from zero to maximum output, default 0.
// - Reversal holds a dead time at the chosen switch point.
// - Switch point: 0 zero freq, 1 start freq, 2 halt speed.
// - Halt speed judged from commanded (0) or measured (1, outside vector PWM) speed.
// - Halt condition must persist for the qualify time.
// - Run terminal is sampled as power-on initialisation ends.
// - Guard 0: active terminal at power-on ignored until re-asserted.
// - Guard 1: active terminal at power-on starts after init.
`timescale 1ns/10ps
module stop_brake_seq
    import stop_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Run commands
    input  wire logic        initDone,
    input  wire logic        runTerminal,
    input  wire logic        directionReq,
    // Speed feedback
    input  wire logic [15:0] commandedFreq,
    input  wire logic [15:0] measuredFreq,
    input  wire logic        vectorPwmMode,
    // Output stage
    output drive_cmd_t       driveCmd
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    stop_cfg_t cfg;
    logic [31:0] statusWord;

    wire apbWrite = psel && penable && pwrite;
    wire mapped   = (paddr[1:0] == 2'h0) && (paddr <= ADDR_STATUS);
    wire [15:0] wr16 = pwdata[15:0];

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg                <= '0;
            cfg.haltThreshold  <= RST_HALT_THRESH;
            cfg.haltQualify    <= RST_HALT_QUAL;
            cfg.switchPoint    <= RST_SWITCH;
            cfg.maxFreq        <= RST_MAX_FREQ;
        end else if (apbWrite && mapped) begin
            case (paddr)
                ADDR_STOP_STYLE:   cfg.stopStyle <= pwdata[0];
                ADDR_BRAKE_FREQ:
                    cfg.brakeStartFreq <= clamp16(wr16, cfg.maxFreq);
                ADDR_DEMAG_WAIT:
                    cfg.demagWait <= clamp16(wr16, LIM_DEMAG_WAIT);
                ADDR_BRAKE_CUR:
                    cfg.brakeCurrent <= clamp16(wr16, LIM_BRAKE_CUR);
                ADDR_BRAKE_DUR:
                    cfg.brakeDuration <= clamp16(wr16, LIM_BRAKE_DUR);
                ADDR_DEADTIME:
                    cfg.deadtime <= (pwdata[23:0] > LIM_DEADTIME) ?
                        LIM_DEADTIME : pwdata[23:0];
                ADDR_SWITCH_POINT:
                    cfg.switchPoint <= (pwdata[1:0] > LIM_SWITCH) ?
                        LIM_SWITCH : pwdata[1:0];
                ADDR_HALT_THRESH:
                    cfg.haltThreshold <= clamp16(wr16, LIM_HALT_THRESH);
                ADDR_HALT_SOURCE:  cfg.haltSource <= pwdata[0];
                ADDR_HALT_QUAL:
                    cfg.haltQualify <= clamp16(wr16, LIM_HALT_QUAL);
                ADDR_RUN_GUARD:    cfg.runGuard <= pwdata[0];
                ADDR_MAX_FREQ:     cfg.maxFreq <= wr16;
                default:           ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_STOP_STYLE:   prdata <= {31'h0, cfg.stopStyle};
                ADDR_BRAKE_FREQ:   prdata <= {16'h0, cfg.brakeStartFreq};
                ADDR_DEMAG_WAIT:   prdata <= {16'h0, cfg.demagWait};
                ADDR_BRAKE_CUR:    prdata <= {16'h0, cfg.brakeCurrent};
                ADDR_BRAKE_DUR:    prdata <= {16'h0, cfg.brakeDuration};
                ADDR_DEADTIME:     prdata <= {8'h0, cfg.deadtime};
                ADDR_SWITCH_POINT: prdata <= {30'h0, cfg.switchPoint};
                ADDR_HALT_THRESH:  prdata <= {16'h0, cfg.haltThreshold};
                ADDR_HALT_SOURCE:  prdata <= {31'h0, cfg.haltSource};
                ADDR_HALT_QUAL:    prdata <= {16'h0, cfg.haltQualify};
                ADDR_RUN_GUARD:    prdata <= {31'h0, cfg.runGuard};
                ADDR_MAX_FREQ:     prdata <= {16'h0, cfg.maxFreq};
                ADDR_STATUS:       prdata <= statusWord;
                default:           prdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Time base: one pulse per 0.01 s
    // ------------------------------------------------------------
    logic [19:0] divCount;
    wire tick = (divCount == 20'(TICK_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!rst_n || tick) begin
            divCount <= 20'h00000;
        end else begin
            divCount <= divCount + 20'h00001;
        end
    end

    // ------------------------------------------------------------
    // Speed and halt detection
    // ------------------------------------------------------------
    // Vector PWM has no usable measurement, so force commanded speed
    wire useMeasured = cfg.haltSource && !vectorPwmMode;
    wire [15:0] speed = useMeasured ? measuredFreq : commandedFreq;
    wire belowHalt = (speed <= cfg.haltThreshold);

    logic haltQualified;
    logic haltTimerDone;

    tick_timer haltTimer (
        .clk      (clk),
        .rst_n    (rst_n),
        .tick     (tick),
        .start    (!belowHalt),
        .duration ({8'h0, cfg.haltQualify}),
        .done     (haltTimerDone)
    );

    always_ff @(posedge clk) begin
        if (!rst_n || !belowHalt) begin
            haltQualified <= 1'b0;
        end else if (haltTimerDone) begin
            haltQualified <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Power-on run guard
    // ------------------------------------------------------------
    logic initSeen;
    logic guardLatched;
    logic runPrev;
    logic runCmd;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            initSeen     <= 1'b0;
            guardLatched <= 1'b0;
            runPrev      <= 1'b0;
            runCmd       <= 1'b0;
        end else begin
            runPrev <= runTerminal;
            if (!initSeen && initDone) begin
                initSeen <= 1'b1;
                // Terminal is sampled as initialisation ends
                guardLatched <= runTerminal && !cfg.runGuard;
                runCmd       <= runTerminal && cfg.runGuard;
            end else if (initSeen) begin
                if (guardLatched) begin
                    if (!runTerminal) begin
                        guardLatched <= 1'b0;
                    end
                    runCmd <= 1'b0;
                end else begin
                    runCmd <= runTerminal;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Stop and reversal sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE, S_RUN, S_RAMP, S_DEMAG, S_BRAKE, S_DEAD
    } seq_state_t;

    seq_state_t state;
    logic       reverseOut;
    logic       timerStart;
    logic       seqTimerDone;
    logic [23:0] timerLen;

    wire brakeEnabled = (cfg.brakeDuration != 16'h0000);
    wire atBrakeFreq  = brakeEnabled &&
                        (commandedFreq <= cfg.brakeStartFreq);
    wire reverseReq   = runCmd && (directionReq != reverseOut);

    // Switch point for the reversal dead time
    wire atSwitch =
        (cfg.switchPoint == 2'(SW_ZERO))  ? (commandedFreq == 16'h0000) :
        (cfg.switchPoint == 2'(SW_START)) ?
            (commandedFreq <= RST_START_FREQ) :
        haltQualified;

    tick_timer seqTimer (
        .clk      (clk),
        .rst_n    (rst_n),
        .tick     (tick),
        .start    (timerStart),
        .duration (timerLen),
        .done     (seqTimerDone)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state      <= S_IDLE;
            reverseOut <= 1'b0;
            timerStart <= 1'b0;
            timerLen   <= 24'h000000;
        end else begin
            timerStart <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (runCmd) begin
                        reverseOut <= directionReq;
                        state      <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (!runCmd) begin
                        // Coast drops output with no braking
                        state <= cfg.stopStyle ? S_IDLE : S_RAMP;
                    end else if (reverseReq) begin
                        state <= S_RAMP;
                    end
                end
                S_RAMP: begin
                    if (reverseReq && atSwitch) begin
                        timerLen   <= cfg.deadtime;
                        timerStart <= 1'b1;
                        state      <= S_DEAD;
                    end else if (!runCmd && atBrakeFreq) begin
                        timerLen   <= {8'h0, cfg.demagWait};
                        timerStart <= 1'b1;
                        state      <= S_DEMAG;
                    end else if (!runCmd && haltQualified) begin
                        state <= S_IDLE;
                    end else if (runCmd && !reverseReq) begin
                        state <= S_RUN;
                    end
                end
                S_DEMAG: begin
                    if (seqTimerDone && !timerStart) begin
                        timerLen   <= {8'h0, cfg.brakeDuration};
                        timerStart <= 1'b1;
                        state      <= S_BRAKE;
                    end
                end
                S_BRAKE: begin
                    if (seqTimerDone && !timerStart) begin
                        state <= S_IDLE;
                    end
                end
                S_DEAD: begin
                    if (seqTimerDone && !timerStart) begin
                        reverseOut <= directionReq;
                        state      <= runCmd ? S_RUN : S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output stage command
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            driveCmd <= '0;
        end else begin
            driveCmd.outputEnable <= (state == S_RUN) ||
                                     (state == S_RAMP) ||
                                     (state == S_BRAKE);
            driveCmd.brakeActive  <= (state == S_BRAKE);
            driveCmd.brakeLevel   <= (state == S_BRAKE) ?
                                     cfg.brakeCurrent : 16'h0000;
            driveCmd.rampDown     <= (state == S_RAMP);
            driveCmd.reverseOut   <= reverseOut;
        end
    end

    assign statusWord = {25'h0, reverseOut, haltQualified, guardLatched,
                         1'b0, state};

endmodule

// File: stop_brake_seq_assertions.sv
`timescale 1ns/10ps
module stop_brake_seq_chk
    import stop_seq_pkg::*;
(
    // Bus
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Run and drive
    input wire logic        initDone,
    input wire logic        runTerminal,
    input wire logic        directionReq,
    input wire drive_cmd_t  driveCmd
);
    // ----
    // Port relations
    // ----
    wire logic badAddr = (paddr[1:0] != 2'h0) || (paddr > ADDR_STATUS);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_bad_read;
        s_acc ##0 (!pwrite && badAddr);
    endsequence
    property p_ready;
        s_acc |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_err;
        s_acc |-> pslverr == badAddr;
    endproperty
    a_err: assert property (p_err) else $error("bad slave error");
    property p_rd_zero;
        s_bad_read |-> prdata == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("unmapped data");
    property p_no_init;
        !initDone |-> !driveCmd.outputEnable;
    endproperty
    a_no_init: assert property (p_no_init) else $error("early run");
    // Brake entry re-enables output with the terminal already released
    property p_start;
        $rose(driveCmd.outputEnable) && !driveCmd.brakeActive |->
            $past(runTerminal, 2);
    endproperty
    a_start: assert property (p_start) else $error("start w/o run");
    property p_excl;
        driveCmd.rampDown |-> !driveCmd.brakeActive;
    endproperty
    a_excl: assert property (p_excl) else $error("brake in ramp");
    property p_demag;
        $rose(driveCmd.brakeActive) |-> !$past(driveCmd.outputEnable);
    endproperty
    a_demag: assert property (p_demag) else $error("no demag gap");
    property p_cap;
        driveCmd.brakeActive |-> driveCmd.brakeLevel <= LIM_BRAKE_CUR;
    endproperty
    a_cap: assert property (p_cap) else $error("brake level");
    property p_rev;
        $changed(driveCmd.reverseOut) |-> driveCmd.reverseOut == directionReq;
    endproperty
    a_rev: assert property (p_rev) else $error("bad reversal");
endmodule

bind stop_brake_seq stop_brake_seq_chk u_chk (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .initDone(initDone), .runTerminal(runTerminal),
    .directionReq(directionReq), .driveCmd(driveCmd));

// File: motor_side_model.sv
`timescale 1ns/10ps
module motor_side_model
    import stop_seq_pkg::*;
(
    // Bench side
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        runReq,
    input  wire logic        dirReq,
    input  wire logic        slow,
    input  wire logic [15:0] measBias,
    // Drive side
    input  wire drive_cmd_t  driveCmd,
    output logic             runTerminal,
    output logic             directionReq,
    output logic [15:0]      commandedFreq,
    output logic [15:0]      measuredFreq
);
    // ----
    // Terminal and frequency ramp
    // ----
    // Release then re-press clears a guarded start
    assign runTerminal  = runReq;
    assign directionReq = dirReq;
    // Bias keeps measured speed above the commanded one
    assign measuredFreq = commandedFreq + measBias;
    wire logic [15:0] step = slow ? 16'h0001 : 16'h0008;
    always_ff @(posedge clk) begin
        if (!rst_n || !driveCmd.outputEnable) begin
            commandedFreq <= 16'h0000;
        end else if (driveCmd.rampDown) begin
            commandedFreq <= (commandedFreq > step) ?
                             commandedFreq - step : 16'h0000;
        end else if (commandedFreq < 16'h0400) begin
            commandedFreq <= commandedFreq + step;
        end
    end
endmodule

// File: drive_stop_brake_sequencer_bench.sv
`timescale 1ns/10ps
module drive_stop_brake_sequencer_bench;
    import stop_seq_pkg::*;
    // ----
    // Signals
    // ----
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, initDone = 1'b0, runReq = 1'b0;
    logic        dirReq = 1'b0, slow = 1'b0, vectorPwmMode = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, seed = 32'h72b1700a, rd, prdata;
    logic [15:0] measBias = 16'h0, commandedFreq, measuredFreq;
    logic        err, pready, pslverr, runTerminal, directionReq;
    drive_cmd_t  driveCmd;
    int          errCount = 0, checksDone = 0;
    wire logic [3:0] flags = {driveCmd.outputEnable, driveCmd.brakeActive,
                              driveCmd.rampDown, driveCmd.reverseOut};

    stop_brake_seq dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .initDone(initDone),
        .runTerminal(runTerminal), .directionReq(directionReq),
        .commandedFreq(commandedFreq), .measuredFreq(measuredFreq),
        .vectorPwmMode(vectorPwmMode), .driveCmd(driveCmd));
    motor_side_model far (.clk(clk), .rst_n(rst_n), .runReq(runReq),
        .dirReq(dirReq), .slow(slow), .measBias(measBias),
        .driveCmd(driveCmd), .runTerminal(runTerminal),
        .directionReq(directionReq), .commandedFreq(commandedFreq),
        .measuredFreq(measuredFreq));

    initial begin
        forever #5 clk = ~clk;
    end

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] clampTo(input logic [31:0] d, lim);
        return (d > lim) ? lim : d;
    endfunction
    function automatic logic [15:0] expTh(input int s);
        return (s == 0) ? 16'h0 : (s == 1) ? RST_START_FREQ : 16'h0090;
    endfunction
    task automatic chk(input logic [31:0] got, exp, input string what);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: %s %h/%h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic isWr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= isWr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        chk(pready, 1'b1, "ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic waitFor(input int b, input logic v);
        int n;
        n = 0;
        while (flags[b] !== v && n < 20000) begin
            @(posedge clk);
            n++;
        end
        chk(flags[b], v, "drive flag");
    endtask
    task automatic boot(input logic run, guard);
        rst_n <= 1'b0;
        initDone <= 1'b0;
        runReq <= run;
        dirReq <= 1'b0;
        vectorPwmMode <= 1'b0;
        measBias <= 16'h0;
        slow <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wr(ADDR_RUN_GUARD, {31'h0, guard});
        wr(ADDR_HALT_QUAL, 32'h0);
        initDone <= 1'b1;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        errCount++;
        $display("wrong value at %0t: watchdog", $time);
        stop_test();
    end

    // ----
    // Scenarios
    // ----
    initial begin
        logic [31:0] lim [11];
        logic [31:0] rv [9];
        int          w [11];
        logic [31:0] d, r;
        logic [15:0] th, cur;
        w = '{1, 16, 16, 16, 16, 24, 2, 16, 1, 16, 1};
        rv = '{0, 0, 0, 0, 0, 0, RST_SWITCH, RST_HALT_THRESH, 0};
        boot(1'b0, 1'b0);
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, rv[i], "reset value");
        end
        r = xs();
        wr(ADDR_MAX_FREQ, {16'h0, r[15:0]});
        lim = '{1, r[15:0], LIM_DEMAG_WAIT, LIM_BRAKE_CUR, LIM_BRAKE_DUR,
                LIM_DEADTIME, LIM_SWITCH, LIM_HALT_THRESH, 1, LIM_HALT_QUAL, 1};
        for (int k = 0; k < 44; k++) begin
            r = xs();
            d = (xs() & ((32'h1 << w[k % 11]) - 1)) >> r[3:0];
            wr(8'(4 * (k % 11)), d);
            apb(1'b0, 8'(4 * (k % 11)), 32'h0);
            chk(rd, clampTo(d, lim[k % 11]), "clamp");
        end
        wr(8'h34, 32'h5);
        chk(err, 1'b1, "unmapped write");
        apb(1'b0, 8'h34, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        apb(1'b0, 8'h06, 32'h0);
        chk(err, 1'b1, "unaligned");
        // Terminal held through power-on must not start the drive
        boot(1'b1, 1'b0);
        repeat (20) @(posedge clk);
        chk(flags[3], 1'b0, "guarded start");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[ST_GUARD_BIT], 1'b1, "guard flag");
        runReq <= 1'b0;
        repeat (5) @(posedge clk);
        runReq <= 1'b1;
        waitFor(3, 1'b1);
        boot(1'b1, 1'b1);
        waitFor(3, 1'b1);
        wr(ADDR_STOP_STYLE, 32'h1);
        repeat (50) @(posedge clk);
        runReq <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(flags[3], 1'b0, "coast");
        boot(1'b1, 1'b1);
        cur = 16'(xs() % 1001);
        wr(ADDR_BRAKE_FREQ, 32'h100);
        wr(ADDR_BRAKE_CUR, {16'h0, cur});
        wr(ADDR_BRAKE_DUR, 32'h5);
        repeat (200) @(posedge clk);
        runReq <= 1'b0;
        waitFor(1, 1'b1);
        waitFor(1, 1'b0);
        // Two ramp steps pass before the output stage sees the block
        r = {16'h0, commandedFreq};
        chk(r >= 32'he0 && r <= 32'h100, 1'b1, "brake entry");
        waitFor(2, 1'b1);
        chk(driveCmd.brakeLevel, cur, "brake level");
        // Slow ramp so the stop point is resolved to a few counts
        boot(1'b1, 1'b1);
        th = 16'h40 + 16'(xs() % 256);
        wr(ADDR_HALT_THRESH, {16'h0, th});
        wr(ADDR_BRAKE_FREQ, 32'h200);
        repeat (200) @(posedge clk);
        slow <= 1'b1;
        runReq <= 1'b0;
        waitFor(1, 1'b1);
        waitFor(3, 1'b0);
        chk(commandedFreq <= th && commandedFreq + 8 >= th, 1, "halt");
        repeat (10) @(posedge clk);
        chk(flags[2], 1'b0, "no brake");
        boot(1'b1, 1'b1);
        wr(ADDR_HALT_SOURCE, 32'h1);
        measBias <= 16'h1000;
        repeat (200) @(posedge clk);
        runReq <= 1'b0;
        repeat (2000) @(posedge clk);
        chk(flags[3], 1'b1, "measured speed");
        vectorPwmMode <= 1'b1;
        waitFor(3, 1'b0);
        boot(1'b1, 1'b1);
        wr(ADDR_HALT_THRESH, 32'h90);
        for (int s = 0; s < 3; s++) begin
            wr(ADDR_SWITCH_POINT, s);
            repeat (200) @(posedge clk);
            d[0] = ~dirReq;
            dirReq <= d[0];
            waitFor(3, 1'b0);
            th = commandedFreq;
            chk(th <= expTh(s) && th + 16'h20 >= expTh(s), 1, "turn");
            waitFor(0, d[0]);
        end
        stop_test();
    end
endmodule
